// ===== shared/emi_defines.vh
`ifndef EMI_DEFINES_VH
`define EMI_DEFINES_VH

`define EMI_STATIC_REGIONS  4'h6
`define EMI_SDRAM_REGION0   4'hC
`define EMI_SDRAM_REGION1   4'hD

`define EMI_W8              2'h0
`define EMI_W16             2'h1
`define EMI_W32             2'h2

`define EMI_CLK_NS          10
`define EMI_REFRESH_NS      7800
`define EMI_REFRESH_CYCLES  (`EMI_REFRESH_NS / `EMI_CLK_NS)

`define EMI_TRCD_TICKS      3'h1
`define EMI_CAS_TICKS       3'h2
`define EMI_WR_TICKS        3'h3
`define EMI_TRC_TICKS       3'h4
`define EMI_SREX_TICKS      3'h4

`define EMI_CMD_NOP         3'h7
`define EMI_CMD_ACT         3'h3
`define EMI_CMD_RD          3'h5
`define EMI_CMD_WR          3'h4
`define EMI_CMD_REF         3'h1

`endif

// ===== hw/emi_sdram_seq.v
`timescale 1ns/1ps
`default_nettype none
`include "emi_defines.vh"
module emi_sdram_seq (
  input  wire        sys_clk_in,
  input  wire        rst_n_in,
  input  wire        tick_in,
  input  wire        go_in,
  input  wire        write_in,
  input  wire        chip_in,
  input  wire [12:0] row_in,
  input  wire [8:0]  col_in,
  input  wire [1:0]  ibank_in,
  input  wire        sleep_in,
  input  wire        bus_free_in,
  output reg  [1:0]  cs_n_out,
  output reg         ras_n_out,
  output reg         cas_n_out,
  output reg         we_n_out,
  output reg         cke_out,
  output reg  [14:0] dra_out,
  output reg         done_out,
  output wire        busy_out,
  output wire        sref_out
);
  localparam S_IDLE  = 3'h0;
  localparam S_ACT_W = 3'h1;
  localparam S_RW_W  = 3'h2;
  localparam S_REF_W = 3'h3;
  localparam S_SREF  = 3'h4;
  localparam S_EXIT  = 3'h5;
  localparam integer REF_RELOAD = `EMI_REFRESH_CYCLES - 1;

  reg [2:0] state;
  reg [2:0] cnt;
  reg [9:0] ref_cnt;
  reg       ref_pend;
  wire [31:0] ref_reload = REF_RELOAD;
  wire      ref_issue = tick_in & (state == S_IDLE) & ref_pend & bus_free_in;
  wire [1:0] chip_cs_n = chip_in ? 2'h1 : 2'h2;

  assign busy_out = (state != S_IDLE) | ref_pend;
  assign sref_out = (state == S_SREF);

  // Refresh request, new expiry beats the clear
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_cnt  <= 10'h000;
      ref_pend <= 1'b0;
    end else begin
      if (ref_cnt == 10'h000) begin
        ref_cnt <= ref_reload[9:0];
      end else begin
        ref_cnt <= ref_cnt - 10'h001;
      end
      ref_pend <= (ref_cnt == 10'h000) | (ref_pend & ~ref_issue);
    end
  end

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state     <= S_IDLE;
      cnt       <= 3'h0;
      cs_n_out  <= 2'h3;
      ras_n_out <= 1'b1;
      cas_n_out <= 1'b1;
      we_n_out  <= 1'b1;
      cke_out   <= 1'b1;
      dra_out   <= 15'h0000;
      done_out  <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (tick_in) begin
        cs_n_out <= 2'h3;
        {ras_n_out, cas_n_out, we_n_out} <= `EMI_CMD_NOP;
        case (state)
          S_IDLE: begin
            if (sleep_in & bus_free_in & ~ref_pend) begin
              cs_n_out <= 2'h0;
              {ras_n_out, cas_n_out, we_n_out} <= `EMI_CMD_REF;
              cke_out <= 1'b0;
              state   <= S_SREF;
            end else if (ref_pend & bus_free_in) begin
              cs_n_out <= 2'h0;
              {ras_n_out, cas_n_out, we_n_out} <= `EMI_CMD_REF;
              cnt   <= `EMI_TRC_TICKS;
              state <= S_REF_W;
            end else if (go_in) begin
              cs_n_out <= chip_cs_n;
              {ras_n_out, cas_n_out, we_n_out} <= `EMI_CMD_ACT;
              dra_out <= {ibank_in, row_in};
              cnt     <= `EMI_TRCD_TICKS;
              state   <= S_ACT_W;
            end
          end
          S_ACT_W: begin
            if (cnt == 3'h0) begin
              cs_n_out <= chip_cs_n;
              {ras_n_out, cas_n_out, we_n_out} <= write_in ? `EMI_CMD_WR : `EMI_CMD_RD;
              // Address bit 10 high: auto precharge
              dra_out <= {ibank_in, 4'h2, col_in};
              cnt     <= write_in ? `EMI_WR_TICKS : `EMI_CAS_TICKS;
              state   <= S_RW_W;
            end else begin
              cnt <= cnt - 3'h1;
            end
          end
          S_RW_W: begin
            if (cnt == 3'h0) begin
              done_out <= 1'b1;
              state    <= S_IDLE;
            end else begin
              cnt <= cnt - 3'h1;
            end
          end
          S_REF_W: begin
            if (cnt == 3'h0) begin
              state <= S_IDLE;
            end else begin
              cnt <= cnt - 3'h1;
            end
          end
          S_SREF: begin
            if (!sleep_in) begin
              cke_out <= 1'b1;
              cnt     <= `EMI_SREX_TICKS;
              state   <= S_EXIT;
            end
          end
          S_EXIT: begin
            if (cnt == 3'h0) begin
              state <= S_IDLE;
            end else begin
              cnt <= cnt - 3'h1;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/emi_top.v
`timescale 1ns/1ps
`default_nettype none
`include "emi_defines.vh"
module emi_top (
  input  wire        sys_clk_in,
  input  wire        rst_n_in,
  input  wire        req_valid_in,
  input  wire        req_write_in,
  input  wire [31:0] req_addr_in,
  input  wire [1:0]  req_size_in,
  input  wire [31:0] req_wdata_in,
  output wire        req_ready_out,
  output reg         rsp_valid_out,
  output reg         rsp_error_out,
  output reg  [31:0] rsp_rdata_out,
  input  wire [11:0] bank_width_in,
  input  wire [23:0] bank_wait_in,
  input  wire [5:0]  bank_burst_in,
  input  wire        sdram_wide_in,
  input  wire        standby_req_in,
  output wire        standby_ack_out,
  output reg  [5:0]  static_bank_select_n_out,
  output wire [27:0] mem_addr_out,
  output reg  [31:0] mem_data_out,
  output reg         mem_data_oe_out,
  input  wire [31:0] mem_data_in,
  output wire        halfword_sel_out,
  output wire        word_sel_out,
  output wire        oe_cas_n_out,
  output wire        we_n_out,
  output wire        dir_ras_out,
  output reg         sdram_clock_out,
  output wire        sdram_clock_enable_out,
  output wire [1:0]  sdram_bank_select_n_out,
  output reg  [3:0]  sdram_byte_mask_out
);
  localparam T_IDLE    = 3'h0;
  localparam T_BEAT    = 3'h1;
  localparam T_ST_ADDR = 3'h2;
  localparam T_ST_STB  = 3'h3;
  localparam T_SD      = 3'h4;

  function [3:0] lanes;
    input [1:0] a;
    input [1:0] w;
    begin
      case (w)
        `EMI_W8:  lanes = 4'h1 << a;
        `EMI_W16: lanes = a[1] ? 4'hC : 4'h3;
        default:  lanes = 4'hF;
      endcase
    end
  endfunction

  function [4:0] lane_shift;
    input [1:0] a;
    input [1:0] w;
    begin
      case (w)
        `EMI_W8:  lane_shift = {a, 3'h0};
        `EMI_W16: lane_shift = {a[1], 4'h0};
        default:  lane_shift = 5'h00;
      endcase
    end
  endfunction

  function [14:0] rev15;
    input [14:0] d;
    integer i;
    begin
      for (i = 0; i < 15; i = i + 1) begin
        rev15[i] = d[14 - i];
      end
    end
  endfunction

  reg [2:0]  state;
  reg [3:0]  region;
  reg        wr;
  reg [1:0]  ew;
  reg [1:0]  bw;
  reg [2:0]  beats;
  reg [27:0] baddr;
  reg [31:0] wdata;
  reg [31:0] rdata;
  reg [3:0]  wait_cfg;
  reg        burst_en;
  reg        burst_cont;
  reg [3:0]  cnt;
  reg        st_oe_n;
  reg        st_we_n;
  reg        sd_go;
  reg [31:0] merged;
  integer    k;

  // Request decode
  wire [3:0] req_region = req_addr_in[31:28];
  wire [2:0] req_bank   = req_region[2:0];
  // one select per 256 MB region
  wire       req_static = (req_region < `EMI_STATIC_REGIONS);
  wire       req_sd     = (req_region == `EMI_SDRAM_REGION0) |
                          (req_region == `EMI_SDRAM_REGION1);
  wire [1:0] req_cfg_w  = bank_width_in[{req_bank, 1'b0} +: 2];
  wire [1:0] req_size   = (req_size_in == 2'h3) ? `EMI_W32 : req_size_in;
  wire [1:0] req_ew     = req_static ? ((req_cfg_w == 2'h3) ? `EMI_W32 : req_cfg_w)
                                     : (sdram_wide_in ? `EMI_W32 : `EMI_W16);
  wire [1:0] req_bw     = (req_size < req_ew) ? req_size : req_ew;
  wire [1:0] req_nshift = req_size - req_bw;
  wire [2:0] req_beats  = 3'h1 << req_nshift;

  wire       sd_done;
  wire       sd_busy;
  wire       sd_ras_n;
  wire       sd_cas_n;
  wire       sd_we_n;
  wire [14:0] sd_dra;
  wire       static_active = (state == T_ST_ADDR) | (state == T_ST_STB);
  wire       last_beat     = (beats == 3'h1);
  wire [27:0] step         = 28'h1 << bw;
  wire [4:0] shift         = lane_shift(baddr[1:0], ew);
  wire [3:0] beat_lanes    = lanes(baddr[1:0], bw);
  wire [31:0] rd_aligned   = mem_data_in << shift;
  wire       tick          = sdram_clock_out;

  wire [12:0] sd_row  = sdram_wide_in ? baddr[23:11] : baddr[22:10];
  wire [8:0]  sd_col  = sdram_wide_in ? baddr[10:2]  : baddr[9:1];
  wire [1:0]  sd_ib   = sdram_wide_in ? baddr[25:24] : baddr[24:23];

  assign req_ready_out = (state == T_IDLE) & ~standby_req_in & ~sd_busy;

  assign halfword_sel_out = static_active & (bw == `EMI_W16);
  assign word_sel_out     = static_active & (bw == `EMI_W32);
  assign oe_cas_n_out = static_active ? st_oe_n : sd_cas_n;
  assign we_n_out     = static_active ? st_we_n : sd_we_n;
  assign dir_ras_out  = static_active ? wr : sd_ras_n;
  assign mem_addr_out = static_active ? baddr : {rev15(sd_dra), 13'h0000};

  always @* begin
    merged = rdata;
    for (k = 0; k < 4; k = k + 1) begin
      if (beat_lanes[k]) begin
        merged[8*k +: 8] = rd_aligned[8*k +: 8];
      end
    end
  end

  // SDRAM clock at half rate, command pins change as it falls
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sdram_clock_out <= 1'b0;
    end else begin
      sdram_clock_out <= ~sdram_clock_out;
    end
  end

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state                    <= T_IDLE;
      region                   <= 4'h0;
      wr                       <= 1'b0;
      ew                       <= `EMI_W32;
      bw                       <= `EMI_W32;
      beats                    <= 3'h0;
      baddr                    <= 28'h0000000;
      wdata                    <= 32'h00000000;
      rdata                    <= 32'h00000000;
      wait_cfg                 <= 4'h0;
      burst_en                 <= 1'b0;
      burst_cont               <= 1'b0;
      cnt                      <= 4'h0;
      st_oe_n                  <= 1'b1;
      st_we_n                  <= 1'b1;
      sd_go                    <= 1'b0;
      rsp_valid_out            <= 1'b0;
      rsp_error_out            <= 1'b0;
      rsp_rdata_out            <= 32'h00000000;
      static_bank_select_n_out <= 6'h3F;
      mem_data_out             <= 32'h00000000;
      mem_data_oe_out          <= 1'b0;
      sdram_byte_mask_out      <= 4'hF;
    end else begin
      rsp_valid_out <= 1'b0;
      case (state)
        T_IDLE: begin
          if (req_valid_in & req_ready_out) begin
            region     <= req_region;
            wr         <= req_write_in;
            ew         <= req_ew;
            bw         <= req_bw;
            beats      <= req_beats;
            baddr      <= req_addr_in[27:0];
            wdata      <= req_wdata_in;
            rdata      <= 32'h00000000;
            wait_cfg   <= bank_wait_in[{req_bank, 2'h0} +: 4];
            burst_en   <= bank_burst_in[req_bank];
            burst_cont <= 1'b0;
            if (req_static | req_sd) begin
              state <= T_BEAT;
            end else begin
              rsp_valid_out <= 1'b1;
              rsp_error_out <= 1'b1;
              rsp_rdata_out <= 32'h00000000;
            end
          end
        end
        T_BEAT: begin
          mem_data_out    <= wdata >> shift;
          mem_data_oe_out <= wr;
          rsp_error_out   <= 1'b0;
          if (region < `EMI_STATIC_REGIONS) begin
            static_bank_select_n_out <= ~(6'h01 << region[2:0]);
            // wait states, none inside a burst
            cnt   <= burst_cont ? 4'h0 : wait_cfg;
            state <= T_ST_ADDR;
          end else begin
            sdram_byte_mask_out <= ~(beat_lanes >> shift[4:3]);
            sd_go <= 1'b1;
            state <= T_SD;
          end
        end
        T_ST_ADDR: begin
          st_oe_n <= wr;
          st_we_n <= ~wr;
          state   <= T_ST_STB;
        end
        T_ST_STB: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else begin
            rdata <= merged;
            if (last_beat) begin
              st_oe_n                  <= 1'b1;
              st_we_n                  <= 1'b1;
              static_bank_select_n_out <= 6'h3F;
              mem_data_oe_out          <= 1'b0;
              rsp_valid_out            <= 1'b1;
              rsp_rdata_out            <= wr ? 32'h00000000 : merged;
              state                    <= T_IDLE;
            end else begin
              baddr      <= baddr + step;
              beats      <= beats - 3'h1;
              burst_cont <= burst_en;
              // burst reads keep the strobe low
              if (burst_en & ~wr) begin
                cnt <= 4'h0;
              end else begin
                st_oe_n <= 1'b1;
                st_we_n <= 1'b1;
                state   <= T_BEAT;
              end
            end
          end
        end
        T_SD: begin
          if (sd_done) begin
            rdata <= merged;
            sd_go <= 1'b0;
            sdram_byte_mask_out <= 4'hF;
            if (last_beat) begin
              mem_data_oe_out <= 1'b0;
              rsp_valid_out   <= 1'b1;
              rsp_rdata_out   <= wr ? 32'h00000000 : merged;
              state           <= T_IDLE;
            end else begin
              baddr <= baddr + step;
              beats <= beats - 3'h1;
              state <= T_BEAT;
            end
          end
        end
        default: state <= T_IDLE;
      endcase
    end
  end

  emi_sdram_seq u_seq (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_n_in),
    .tick_in     (tick),
    .go_in       (sd_go),
    .write_in    (wr),
    .chip_in     (region[0]),
    .row_in      (sd_row),
    .col_in      (sd_col),
    .ibank_in    (sd_ib),
    .sleep_in    (standby_req_in & (state == T_IDLE)),
    .bus_free_in (state == T_IDLE),
    .cs_n_out    (sdram_bank_select_n_out),
    .ras_n_out   (sd_ras_n),
    .cas_n_out   (sd_cas_n),
    .we_n_out    (sd_we_n),
    .cke_out     (sdram_clock_enable_out),
    .dra_out     (sd_dra),
    .done_out    (sd_done),
    .busy_out    (sd_busy),
    .sref_out    (standby_ack_out)
  );
endmodule
`default_nettype wire

// ===== verification/emi_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module emi_top_checker (
  input wire logic       sys_clk_in,
  input wire logic       rst_n_in,
  input wire logic       req_ready_out,
  input wire logic       rsp_valid_out,
  input wire logic       standby_ack_out,
  input wire logic [5:0] static_bank_select_n_out,
  input wire logic       halfword_sel_out,
  input wire logic       word_sel_out,
  input wire logic       oe_cas_n_out,
  input wire logic       we_n_out,
  input wire logic       dir_ras_out,
  input wire logic       sdram_clock_out,
  input wire logic       sdram_clock_enable_out,
  input wire logic [1:0] sdram_bank_select_n_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire st_on = ~&static_bank_select_n_out;
  sequence s_nop;
    dir_ras_out && oe_cas_n_out && we_n_out;
  endsequence
  sequence s_ref_all;
    sdram_bank_select_n_out == 2'h0 && !dir_ras_out && !oe_cas_n_out && we_n_out;
  endsequence
  property p_one_bank; $onehot0(~static_bank_select_n_out); endproperty
  a_one_bank: assert property (p_one_bank) else $error("two static selects low");
  property p_width_sel; !(halfword_sel_out && word_sel_out); endproperty
  a_width_sel: assert property (p_width_sel) else $error("half and word both set");
  property p_write_dir; st_on && !we_n_out |-> dir_ras_out; endproperty
  a_write_dir: assert property (p_write_dir) else $error("write strobe without direction");
  property p_read_dir; st_on && !oe_cas_n_out |-> !dir_ras_out; endproperty
  a_read_dir: assert property (p_read_dir) else $error("read strobe with write direction");
  property p_sref_entry; $fell(sdram_clock_enable_out) |-> s_ref_all; endproperty
  a_sref_entry: assert property (p_sref_entry) else $error("self-refresh entry not a refresh");
  property p_cke_low; !sdram_clock_enable_out |-> standby_ack_out && !req_ready_out; endproperty
  a_cke_low: assert property (p_cke_low) else $error("clock enable low outside standby");
  property p_exit_nop; $rose(sdram_clock_enable_out) |-> s_nop [*6]; endproperty
  a_exit_nop: assert property (p_exit_nop) else $error("command during self-refresh exit");
  property p_rsp_pulse; rsp_valid_out |=> !rsp_valid_out; endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("response longer than one cycle");
  property p_sdram_clock_out_run; 1'b1 |=> sdram_clock_out != $past(sdram_clock_out); endproperty
  a_sdram_clock_out_run: assert property (p_sdram_clock_out_run) else $error("memory clock stalled");
  property p_cmd_edge; $changed(sdram_bank_select_n_out) |-> $fell(sdram_clock_out); endproperty
  a_cmd_edge: assert property (p_cmd_edge) else $error("select moved off falling clock");
endmodule
bind emi_top emi_top_checker u_chk (.sys_clk_in, .rst_n_in, .req_ready_out, .rsp_valid_out,
  .standby_ack_out, .static_bank_select_n_out, .halfword_sel_out, .word_sel_out,
  .oe_cas_n_out, .we_n_out, .dir_ras_out, .sdram_clock_out, .sdram_clock_enable_out,
  .sdram_bank_select_n_out);
`default_nettype wire

// ===== verification/emi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module emi_mem_model (
  input  wire logic        sys_clk_in,
  input  wire logic [5:0]  static_bank_select_n_in,
  input  wire logic        oe_n_in,
  input  wire logic [27:0] addr_in,
  output var  logic [31:0] data_out
);
  logic [31:0] junk = 32'h0;
  logic [31:0] pat;
  integer      i;
  // Released bus keeps changing
  always @(posedge sys_clk_in) junk <= ~junk;
  always @* begin
    for (i = 0; i < 4; i = i + 1) pat[i*8 +: 8] = (addr_in[7:0] + i[7:0]) ^ 8'h5A;
    data_out = (~&static_bank_select_n_in && !oe_n_in) ? pat : junk;
  end
endmodule
`default_nettype wire

// ===== verification/emi_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module emi_top_bench;
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        req_valid_in = 1'b0;
  logic        req_write_in = 1'b0;
  logic [31:0] req_addr_in = 32'h0;
  logic [1:0]  req_size_in = 2'h0;
  logic [31:0] req_wdata_in = 32'h0;
  logic [11:0] bank_width_in = 12'h784;
  logic [23:0] bank_wait_in = 24'h301020;
  logic [5:0]  bank_burst_in = 6'h04;
  logic        sdram_wide_in = 1'b1;
  logic        standby_req_in = 1'b0;
  wire         req_ready_out, rsp_valid_out, rsp_error_out, mem_data_oe_out, standby_ack_out;
  wire         halfword_sel_out, word_sel_out, oe_cas_n_out, we_n_out, dir_ras_out;
  wire         sdram_clock_out, sdram_clock_enable_out;
  wire [31:0]  rsp_rdata_out, mem_data_out, mem_data_in;
  wire [27:0]  mem_addr_out;
  wire [5:0]   static_bank_select_n_out;
  wire [1:0]   sdram_bank_select_n_out;
  wire [3:0]   sdram_byte_mask_out;
  integer      fails = 0, total_checks = 0, lat = 0, stb_cnt = 0, wr_cnt = 0;
  integer      wid [0:5] = '{0, 1, 0, 2, 3, 1};
  logic [5:0]  cs_seen;
  logic        hw_seen, wd_seen, last_we = 1'b1;
  logic [27:0] act_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_mask;
  logic [1:0]  wr_cs;

  emi_top uut (.*);
  emi_mem_model u_mem (.sys_clk_in, .static_bank_select_n_in(static_bank_select_n_out),
    .oe_n_in(oe_cas_n_out), .addr_in(mem_addr_out), .data_out(mem_data_in));

  initial forever #5 sys_clk_in = ~sys_clk_in;

  // Pin watcher on settled values
  always @(negedge sys_clk_in) begin
    last_we <= we_n_out;
    if (~&static_bank_select_n_out) begin
      cs_seen <= cs_seen | ~static_bank_select_n_out;
      hw_seen <= hw_seen | halfword_sel_out;
      wd_seen <= wd_seen | word_sel_out;
      if (last_we && !we_n_out) stb_cnt <= stb_cnt + 1;
    end
    // Commands stand two cycles, count once while memory clock high
    if (sdram_clock_out && sdram_bank_select_n_out != 2'h3 && oe_cas_n_out && we_n_out
        && !dir_ras_out)
      act_addr <= mem_addr_out;
    if (sdram_clock_out && sdram_bank_select_n_out != 2'h3 && !oe_cas_n_out && !we_n_out
        && dir_ras_out) begin
      wr_cnt <= wr_cnt + 1;
      wr_mask <= sdram_byte_mask_out;
      wr_data <= mem_data_oe_out ? mem_data_out : ~mem_data_out;
      wr_cs <= sdram_bank_select_n_out;
    end
  end

  function [31:0] mem_word(input [31:0] a);
    integer i;
    for (i = 0; i < 4; i = i + 1) mem_word[i*8 +: 8] = (a[7:0] + i[7:0]) ^ 8'h5A;
  endfunction

  function [12:0] rev13(input [12:0] x);
    integer i;
    for (i = 0; i < 13; i = i + 1) rev13[12-i] = x[i];
  endfunction

  function logic sig(input integer k);
    sig = (k == 0) ? req_ready_out : (k == 1) ? rsp_valid_out : standby_ack_out;
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task wait_sig(input integer k, input logic v);
    integer n;
    begin
      n = 0;
      @(negedge sys_clk_in);
      while (sig(k) !== v && n < 3000) begin
        @(negedge sys_clk_in);
        n = n + 1;
      end
      lat = n;
      if (n == 3000) chk({31'h0, sig(k)}, {31'h0, v});
    end
  endtask

  task acc(input logic w, input [31:0] a, input [1:0] s, input [31:0] d);
    begin
      cs_seen = 6'h0;
      hw_seen = 1'b0;
      wd_seen = 1'b0;
      stb_cnt = 0;
      wr_cnt = 0;
      @(posedge sys_clk_in);
      req_valid_in <= 1'b1;
      req_write_in <= w;
      req_addr_in <= a;
      req_size_in <= s;
      req_wdata_in <= d;
      wait_sig(0, 1'b1);
      @(posedge sys_clk_in);
      req_valid_in <= 1'b0;
      wait_sig(1, 1'b1);
    end
  endtask

  task t_banks;
    integer n;
    logic [31:0] a;
    begin
      for (n = 0; n < 6; n = n + 1) begin
        a = {n[3:0], 28'h0000104};
        acc(1'b1, a, 2'h2, 32'hA1B2C3D4);
        chk(stb_cnt, wid[n] == 0 ? 4 : wid[n] == 1 ? 2 : 1);
        acc(1'b0, a, 2'h2, 32'h0);
        chk({26'h0, cs_seen}, 32'h1 << n);
        chk(rsp_rdata_out, mem_word(a));
        chk({hw_seen, wd_seen}, {wid[n] == 1, wid[n] > 1});
      end
    end
  endtask

  task t_waits;
    integer l0;
    begin
      acc(1'b0, 32'h00000201, 2'h0, 32'h0);
      l0 = lat;
      chk(rsp_rdata_out[15:8], 8'h5B);
      acc(1'b0, 32'h10000201, 2'h0, 32'h0);
      chk(lat - l0, 2);
      acc(1'b0, 32'h00000300, 2'h2, 32'h0);
      l0 = lat;
      acc(1'b0, 32'h20000300, 2'h2, 32'h0);
      chk(l0 - lat, 6);
    end
  endtask

  task t_unmapped;
    integer n;
    begin
      for (n = 6; n < 16; n = n + 1) if (n < 12 || n > 13) begin
        acc(1'b0, {n[3:0], 28'h40}, 2'h2, 32'h0);
        chk({rsp_error_out, cs_seen, rsp_rdata_out[7:0]}, 15'h4000);
      end
    end
  endtask

  task t_sdram;
    begin
      acc(1'b1, 32'hD0A55806, 2'h0, 32'h00770000);
      chk({wr_mask, wr_cs, wr_data[23:16]}, {4'hB, 2'h1, 8'h77});
      chk(act_addr[27:15], rev13(13'h14AB));
      @(posedge sys_clk_in);
      sdram_wide_in <= 1'b0;
      acc(1'b1, 32'hC0000010, 2'h2, 32'h12345678);
      chk(wr_cnt, 2);
      @(posedge sys_clk_in);
      sdram_wide_in <= 1'b1;
      acc(1'b1, 32'hC0000010, 2'h2, 32'h12345678);
      chk({wr_cnt[3:0], wr_mask, wr_cs}, {4'h1, 4'h0, 2'h2});
    end
  endtask

  task t_standby;
    begin
      @(posedge sys_clk_in);
      standby_req_in <= 1'b1;
      wait_sig(2, 1'b1);
      chk({sdram_clock_enable_out, req_ready_out}, 2'h0);
      repeat (30) @(posedge sys_clk_in);
      standby_req_in <= 1'b0;
      wait_sig(2, 1'b0);
      chk(sdram_clock_enable_out, 1'b1);
      acc(1'b1, 32'hC0000020, 2'h2, 32'h0BADF00D);
      chk(wr_cnt, 1);
    end
  endtask

  task conclude;
    begin
      $display("Checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  initial begin
    repeat (12) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_banks;
    t_waits;
    t_unmapped;
    t_sdram;
    t_standby;
    conclude;
  end

  initial begin
    #300000;
    fails = fails + 1;
    conclude;
  end
endmodule
`default_nettype wire
